// ===== design/gcr_top.sv
// Command registers, vertical blank interrupt and pipelined read-back path.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Width limits source load and pixels updated.
// - Control bit 8 gates interrupt generation.
// - Control bit 9 enables video output.
// - Interrupt raised once per vertical blank.
// - Control bits 15:13 pick interrupt line.
// - Command access with bits 2:1 clears interrupt.
// - Reads return source; mask only via copies.
// - Read data high-justified, width sets valid bits.
// - Read cycle loads frame data into source.
// - Read returns latch from previous read.
// - Shifter realigns unaligned fetched pixels.
// - Select 01 decodes bits 2:1 to registers.
// - Source/mask load from frame on read, bus on write.
module gcr_top
  import gcr_pkg::*;
(
  input  wire logic        clk_sys,        // System clock, 100 MHz.
  input  wire logic        srst,           // Synchronous reset, active high.
  input  wire logic [15:1] bus_addr,       // Word address bits of the access.
  input  wire logic        bus_wr,         // One-cycle write strobe.
  input  wire logic        bus_rd,         // One-cycle read strobe.
  input  wire logic [15:0] bus_wdata,      // Write data from the master.
  output logic      [15:0] bus_rdata,      // Read data latch, held between reads.
  input  wire logic [15:0] fb_rdata,       // Frame buffer word at the current XY spot.
  input  wire logic [3:0]  fb_bit_offset,  // Bit offset of the XY spot in that word.
  input  wire logic        vblank_start,   // One-cycle pulse at vertical blank.
  output logic      [7:0]  bint,           // Bus interrupt lines, active high.
  output logic             video_en,       // Video output enable.
  output logic      [7:0]  raster_func,    // Raster function code.
  output logic      [4:0]  op_pixels,      // Pixels one update modifies, 1 to 16.
  output logic      [15:0] mask_word       // Mask register contents.
);

  // The whole register file sits in one record, so reset and the next-state
  // copy stay in step field by field.
  gcr_state_t s_q;  // Registered state.
  gcr_state_t s_d;  // Next state.

  logic [1:0]  sel;         // Register select field of the access.
  logic [1:0]  cmd;         // Command register select field.
  logic [15:0] width_mask;  // Valid bits for the current width.
  logic [15:0] fb_aligned;  // Frame word shifted to the high end.
  logic        clear_hit;   // Access addressed to the interrupt clear.

  // Address fields and the shared datapath terms.
  always_comb begin
    sel        = bus_addr[GCR_ADDR_SEL_MSB:GCR_ADDR_SEL_LSB];
    cmd        = bus_addr[GCR_ADDR_CMD_MSB:GCR_ADDR_CMD_LSB];
    // The mask comes from the stored width, so a width write only affects
    // accesses from the next cycle on.
    width_mask = gcr_valid_mask(s_q.width);
    // Moving the addressed pixel to bit 15 keeps the data high-justified.
    // Bits pushed past bit 15 are lost, which is the intended trim.
    fb_aligned = fb_rdata << fb_bit_offset;
    // The clear works on reads as well, so polling software can use either.
    clear_hit  = (bus_wr || bus_rd) && sel == GCR_SEL_CMD && cmd == GCR_CMD_CLEAR;
  end

  // Next-state logic for every register of the block.
  always_comb begin
    s_d = s_q;
    if (bus_wr) begin
      // A write wins when both strobes are high, since the master never asks
      // for both and the write is the access that changes state.
      // Writes load from the data bus.
      unique case (sel)
        GCR_SEL_XY: begin
          // X and Y registers sit outside this block.
        end
        GCR_SEL_CMD: begin
          // Bits 2:1 choose the command register.
          unique case (cmd)
            GCR_CMD_FUNC:  s_d.func  = bus_wdata[7:0];
            GCR_CMD_WIDTH: s_d.width = bus_wdata[GCR_WIDTH_BITS-1:0];
            GCR_CMD_CTRL:  s_d.ctrl  = bus_wdata;
            GCR_CMD_CLEAR: begin
              // Handled with the pending flag below.
            end
          endcase
        end
        GCR_SEL_SRC:  s_d.src  = bus_wdata & width_mask;
        GCR_SEL_MASK: s_d.mask = bus_wdata & width_mask;
      endcase
    end else if (bus_rd) begin
      // Every read advances the latch whatever it selects, so software may use
      // any read address for the extra pipeline read.
      // The latch takes the source as it stood before this read, so the bus
      // shows after each read the source as the last source read or source write before that read left it.
      s_d.latch = s_q.src & width_mask;
      unique case (sel)
        // A source read fetches the frame word, trimmed to the width.
        GCR_SEL_SRC:  s_d.src  = fb_aligned & width_mask;
        // A mask read loads the mask from the frame buffer.
        GCR_SEL_MASK: s_d.mask = fb_aligned & width_mask;
        GCR_SEL_XY, GCR_SEL_CMD: begin
          // Other reads advance the latch; a clear read also drops the pending flag below.
        end
      endcase
    end
    // Clear first, then set, so a blank in the clear cycle is kept.
    if (clear_hit) begin
      s_d.pend = 1'b0;
    end
    // One request per vertical blank while enabled.
    if (vblank_start && s_q.ctrl[GCR_CTRL_IRQ_EN]) begin
      s_d.pend = 1'b1;
    end
  end

  // A synchronous reset keeps the block in one timing path; the price is
  // that reset needs a running clock.
  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= GCR_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // The pending flag survives a disable and only the lines are masked, so a
  // blank seen before the disable shows again once interrupts return.
  // Outputs; the interrupt line decode keeps a disabled block silent.
  always_comb begin
    bint = 8'h00;
    if (s_q.pend && s_q.ctrl[GCR_CTRL_IRQ_EN]) begin
      bint[s_q.ctrl[GCR_CTRL_LVL_MSB:GCR_CTRL_LVL_LSB]] = 1'b1;
    end
  end

  // The data outputs come straight from the state record, except op_pixels, which goes through gcr_eff_width.
  assign bus_rdata   = s_q.latch;
  assign video_en    = s_q.ctrl[GCR_CTRL_VIDEO];
  assign raster_func = s_q.func;
  assign op_pixels   = gcr_eff_width(s_q.width);
  assign mask_word   = s_q.mask;

  // Checks on the behaviour above.
  // All checks share one clock and are off while reset is held, except the reset check, which stays on.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic ctrl_wr;  // Write to the display control register.
  assign ctrl_wr = bus_wr && sel == GCR_SEL_CMD && cmd == GCR_CMD_CTRL;

  // Width write sets the pixel count on the next cycle.
  property p_width_count;
    bus_wr && sel == GCR_SEL_CMD && cmd == GCR_CMD_WIDTH && bus_wdata[4:0] == 5'h03
      |=> op_pixels == 5'h03 && width_mask == 16'hE000;
  endproperty
  a_width_count: assert property (p_width_count)
    else $error("Width write did not set three pixels.");

  // Disabled interrupts keep every line low.
  property p_irq_gate;
    !s_q.ctrl[GCR_CTRL_IRQ_EN] |-> bint == 8'h00;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Interrupt line raised while disabled.");

  // Video follows bit 9 of the last control write.
  property p_video;
    ctrl_wr |=> video_en == $past(bus_wdata[GCR_CTRL_VIDEO]);
  endproperty
  a_video: assert property (p_video)
    else $error("Video enable did not follow control write.");

  // A blank with interrupts on raises exactly one line next cycle.
  property p_vblank_irq;
    vblank_start && s_q.ctrl[GCR_CTRL_IRQ_EN] && !ctrl_wr
      |=> s_q.pend ##0 $onehot(bint);
  endproperty
  a_vblank_irq: assert property (p_vblank_irq)
    else $error("Vertical blank did not raise an interrupt.");

  // The raised line matches the control level field.
  property p_level;
    s_q.pend && s_q.ctrl[GCR_CTRL_IRQ_EN]
      |-> bint == (8'h01 << s_q.ctrl[GCR_CTRL_LVL_MSB:GCR_CTRL_LVL_LSB]);
  endproperty
  a_level: assert property (p_level)
    else $error("Wrong interrupt line selected.");

  // A clear access without a blank drops the pending flag.
  property p_clear;
    clear_hit && !vblank_start |=> !s_q.pend && bint == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Interrupt clear did not take effect.");

  // A clear racing a blank leaves the request standing.
  property p_set_wins;
    clear_hit && vblank_start && s_q.ctrl[GCR_CTRL_IRQ_EN] && !ctrl_wr |=> s_q.pend;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Blank lost in the clear cycle.");

  // A source read and the next read of any select return the first fetch, justified and trimmed.
  property p_two_reads;
    logic [15:0] v;
    (bus_rd && !bus_wr && sel == GCR_SEL_SRC, v = fb_aligned & width_mask)
      ##1 (bus_rd && !bus_wr && $stable(s_q.width))
      |=> bus_rdata == v;
  endproperty
  a_two_reads: assert property (p_two_reads)
    else $error("Second read did not return the first fetch.");

  // Read data never carries bits below the width.
  property p_justified;
    bus_rd && !bus_wr |=> (bus_rdata & ~$past(width_mask)) == 16'h0000;
  endproperty
  a_justified: assert property (p_justified)
    else $error("Read data not high-justified.");

  // Reset leaves control clear and nothing pending.
  property p_reset;
    @(posedge clk_sys) disable iff (1'b0)
      srst |=> s_q.ctrl == 16'h0000 && !s_q.pend && !video_en;
  endproperty
  a_reset: assert property (p_reset)
    else $error("Reset did not clear control.");

  // A request stays up until a clear access, so a slow handler cannot lose it.
  property p_pend_hold;
    s_q.pend && !clear_hit |=> s_q.pend;
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("Pending interrupt dropped without a clear.");

  // Nothing sets the request but a blank seen with interrupts enabled.
  property p_no_spurious;
    !s_q.pend && !(vblank_start && s_q.ctrl[GCR_CTRL_IRQ_EN]) |=> !s_q.pend;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("Interrupt raised without an enabled blank.");

  // The read latch moves only after a read.
  property p_latch_hold;
    !(bus_rd && !bus_wr) |=> $stable(bus_rdata);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("Read data changed without a read.");

  // A source write keeps no bits below the width.
  property p_src_trim;
    bus_wr && sel == GCR_SEL_SRC |=> (s_q.src & ~$past(width_mask)) == 16'h0000;
  endproperty
  a_src_trim: assert property (p_src_trim)
    else $error("Source holds bits beyond the width.");

  // A mask read from the frame keeps no bits below the width.
  property p_mask_trim;
    bus_rd && !bus_wr && sel == GCR_SEL_MASK |=> (mask_word & ~$past(width_mask)) == 16'h0000;
  endproperty
  a_mask_trim: assert property (p_mask_trim)
    else $error("Mask holds bits beyond the width.");

  // Control changes only on a control write.
  property p_ctrl_hold;
    !ctrl_wr |=> $stable(s_q.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("Control changed without a write.");

  // The pixel count always lies between one and sixteen.
  property p_op_range;
    op_pixels != 5'h00 && op_pixels <= GCR_WIDTH_MAX;
  endproperty
  a_op_range: assert property (p_op_range)
    else $error("Pixel count out of range.");

  // A function write lands in the function register.
  property p_func_write;
    bus_wr && sel == GCR_SEL_CMD && cmd == GCR_CMD_FUNC |=> raster_func == $past(bus_wdata[7:0]);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("Function register did not take the write.");

  // The pixel count moves only on a width write.
  property p_width_hold;
    !(bus_wr && sel == GCR_SEL_CMD && cmd == GCR_CMD_WIDTH) |=> $stable(op_pixels);
  endproperty
  a_width_hold: assert property (p_width_hold)
    else $error("Pixel count changed without a width write.");

  // Cover points show that each main scenario was reached.
  // Main scenarios.
  c_irq_raised: cover property (vblank_start && s_q.ctrl[GCR_CTRL_IRQ_EN] ##1 bint != 8'h00);
  c_two_reads:  cover property (bus_rd && sel == GCR_SEL_SRC ##[1:4] bus_rd);
  c_unaligned:  cover property (bus_rd && sel == GCR_SEL_SRC && fb_bit_offset != 4'h0);
  c_clear:      cover property (s_q.pend ##1 clear_hit ##1 !s_q.pend);
  c_set_wins:   cover property (clear_hit && vblank_start ##1 s_q.pend);

endmodule : gcr_top

`default_nettype wire

// ===== design/gcr_pkg.sv
// Constants, state type and helper functions for the graphics command block.
package gcr_pkg;

  // Register select codes carried on bus address bits 15:14.
  localparam logic [1:0] GCR_SEL_XY   = 2'h0;  // X or Y registers; a read here still advances the read latch.
  localparam logic [1:0] GCR_SEL_CMD  = 2'h1;  // Command registers, chosen by bits 2:1.
  localparam logic [1:0] GCR_SEL_SRC  = 2'h2;  // Source register load.
  localparam logic [1:0] GCR_SEL_MASK = 2'h3;  // Mask register load.

  // Command register codes carried on bus address bits 2:1.
  localparam logic [1:0] GCR_CMD_FUNC  = 2'h0;  // Raster function register.
  localparam logic [1:0] GCR_CMD_WIDTH = 2'h1;  // Operation width register.
  localparam logic [1:0] GCR_CMD_CTRL  = 2'h2;  // Display control register.
  localparam logic [1:0] GCR_CMD_CLEAR = 2'h3;  // Interrupt clear strobe.

  // Bus address field positions.
  localparam int GCR_ADDR_SEL_MSB = 15;  // Top bit of the register select field.
  localparam int GCR_ADDR_SEL_LSB = 14;  // Low bit of the register select field.
  localparam int GCR_ADDR_CMD_MSB = 2;   // Top bit of the command select field.
  localparam int GCR_ADDR_CMD_LSB = 1;   // Low bit of the command select field.

  // Display control field positions.
  localparam int GCR_CTRL_IRQ_EN = 8;   // Interrupt generation enable.
  localparam int GCR_CTRL_VIDEO  = 9;   // Video output enable.
  localparam int GCR_CTRL_LVL_LSB = 13; // Interrupt line select, bits 15:13.
  localparam int GCR_CTRL_LVL_MSB = 15; // Top of the interrupt line select.

  // Width register layout; zero or anything above the maximum means full word.
  localparam int          GCR_WIDTH_BITS = 5;      // Stored width field size.
  localparam logic [4:0]  GCR_WIDTH_MAX  = 5'h10;  // Sixteen pixels per word.
  localparam logic [15:0] GCR_WORD_ONES  = 16'hFFFF;  // All bits of a bus word.

  // Whole state of the block, held as one packed record.
  typedef struct packed {
    logic [7:0]  func;   // Raster function code.
    logic [4:0]  width;  // Operation width as written.
    logic [15:0] ctrl;   // Display control register.
    logic [15:0] src;    // Source register.
    logic [15:0] mask;   // Mask register.
    logic [15:0] latch;  // Read data latch driven to the bus.
    logic        pend;   // Vertical blank interrupt pending.
  } gcr_state_t;

  // Everything clears at reset.
  localparam gcr_state_t GCR_STATE_RST = '0;

  // Effective pixel count, 1 to 16.
  function automatic logic [4:0] gcr_eff_width(input logic [4:0] w);
    gcr_eff_width = (w == 5'h00 || w > GCR_WIDTH_MAX) ? GCR_WIDTH_MAX : w;
  endfunction : gcr_eff_width

  // High-order justified mask with the top n bits set.
  function automatic logic [15:0] gcr_valid_mask(input logic [4:0] w);
    gcr_valid_mask = ~(GCR_WORD_ONES >> gcr_eff_width(w));
  endfunction : gcr_valid_mask

endpackage : gcr_pkg

// ===== tb/gcr_cpu.sv
// Bus master model that issues register reads and writes to the graphics block.
`timescale 1ns/1ps
`default_nettype none
module gcr_cpu (
  input  wire logic        clk_sys,   // System clock.
  output logic      [15:1] bus_addr,  // Access address.
  output logic             bus_wr,    // Write strobe.
  output logic             bus_rd,    // Read strobe.
  output logic      [15:0] bus_wdata  // Write data.
);
  // The bus starts idle with both strobes low.
  initial begin
    bus_addr  = 15'h0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_wdata = 16'hA5A5;
  end
  // One strobe cycle, set at a falling edge and dropped at the next one.
  task automatic access(input logic wr, input logic [15:1] addr, input logic [15:0] data);
    @(negedge clk_sys);
    bus_addr  = addr;
    bus_wdata = data;
    bus_wr    = wr;
    bus_rd    = ~wr;
    @(negedge clk_sys);
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_wdata = ~data;  // Released data must not look like the last value.
  endtask : access
endmodule : gcr_cpu
`default_nettype wire

// ===== tb/graphics_control_and_readback_tb.sv
// Self-checking testbench for the graphics command and read-back block.
`timescale 1ns/1ps
`default_nettype none
module graphics_control_and_readback_tb;
  import gcr_pkg::*;
  logic        clk_sys, srst, bus_wr, bus_rd, vblank_start, video_en, rd_q;
  logic [15:1] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, fb_rdata, mask_word, src_m, d;
  logic [7:0]  bint, raster_func;
  logic [4:0]  op_pixels, width_m;
  logic [3:0]  fb_bit_offset;
  logic [31:0] rng;
  logic [15:0] exp_q[$];  // Expected read data, oldest first.
  int          err_total, samples_checked, cyc;
  gcr_top gcr_top_inst (.clk_sys(clk_sys), .srst(srst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .fb_rdata(fb_rdata),
    .fb_bit_offset(fb_bit_offset), .vblank_start(vblank_start), .bint(bint),
    .video_en(video_en), .raster_func(raster_func), .op_pixels(op_pixels),
    .mask_word(mask_word));
  gcr_cpu gcr_cpu_inst (.clk_sys(clk_sys), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata));
  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Xorshift generator for data, offsets and codes.
  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction : rnd
  // Top n bits set; zero or above sixteen counts as sixteen.
  function automatic logic [15:0] wm(input logic [4:0] w);
    return (w == 5'h00 || w > 5'h10) ? 16'hFFFF : 16'hFFFF << (5'h10 - w);
  endfunction : wm
  function automatic logic [15:1] adr(input logic [1:0] sel, input logic [1:0] cmd);
    return {sel, 11'h000, cmd};
  endfunction : adr
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [1:0] sel, input logic [1:0] cmd, input logic [15:0] v);
    gcr_cpu_inst.access(1'b1, adr(sel, cmd), v);
  endtask : wr
  // A read returns the source as the last source read or source write left it, cut to the width.
  task automatic rd(input logic [1:0] sel, input logic [1:0] cmd, input logic [15:0] v,
                    input logic [3:0] k);
    exp_q.push_back(src_m & wm(width_m));
    fb_rdata      = v;
    fb_bit_offset = k;
    gcr_cpu_inst.access(1'b0, adr(sel, cmd), 16'h0000);
  endtask : rd
  task automatic vbl();
    @(negedge clk_sys);
    vblank_start = 1'b1;
    @(negedge clk_sys);
    vblank_start = 1'b0;
  endtask : vbl
  task automatic give_verdict();
    $display("Checked %0d values, %0d mismatches", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // Watcher: after each sampled read strobe the latch is compared with the oldest note.
  always @(posedge clk_sys) rd_q <= bus_rd;
  always @(negedge clk_sys) begin
    if (rd_q === 1'b1 && exp_q.size() > 0) chk("bus_rdata", exp_q.pop_front(), bus_rdata);
  end
  // Cuts a hang short; the whole run needs well under this many cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {srst, vblank_start, fb_rdata, fb_bit_offset} = {1'b1, 1'b0, 16'h0000, 4'h0};
    {src_m, width_m, rng, err_total, samples_checked} = '0;
    rng = 32'h0000000C;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk("op_pixels", 16'h0010, {11'h000, op_pixels});
    chk("bint", 16'h0000, {8'h00, bint});
    chk("video_en", 16'h0000, {15'h0000, video_en});
    $display("Reset test done");
    // Pipelined fetches at several widths, including the boundary values.
    for (int i = 0; i < 6; i++) begin
      width_m = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h03 :
                (i == 3) ? 5'h07 : (i == 4) ? 5'h10 : 5'h11;
      wr(GCR_SEL_CMD, GCR_CMD_WIDTH, {11'h000, width_m});
      d = (width_m == 5'h00 || width_m > 5'h10) ? 16'h0010 : {11'h000, width_m};
      chk("op_pixels", d, {11'h000, op_pixels});
      repeat (4) begin
        d = rnd();
        rd(GCR_SEL_SRC, GCR_CMD_FUNC, d, d[3:0] ^ 4'h5);
        src_m = (d << (d[3:0] ^ 4'h5)) & wm(width_m);
      end
      rd(GCR_SEL_CMD, GCR_CMD_FUNC, 16'h0000, 4'h0);
      $display("Read-back test at width %0d done", width_m);
    end
    d = rnd();
    wr(GCR_SEL_SRC, GCR_CMD_FUNC, d);
    src_m = d & wm(width_m);
    rd(GCR_SEL_MASK, GCR_CMD_FUNC, ~d, 4'h3);
    chk("mask_word", (~d << 3) & wm(width_m), mask_word);
    wr(GCR_SEL_MASK, GCR_CMD_FUNC, d ^ 16'h0F0F);
    chk("mask_word", (d ^ 16'h0F0F) & wm(width_m), mask_word);
    wr(GCR_SEL_CMD, GCR_CMD_FUNC, d);
    chk("raster_func", {8'h00, d[7:0]}, {8'h00, raster_func});
    $display("Source, mask and function test done");
    // Every interrupt line, cleared alternately by write and by read.
    for (int l = 0; l < 8; l++) begin
      wr(GCR_SEL_CMD, GCR_CMD_CTRL, {l[2:0], 3'h0, 2'h3, 8'h00});
      chk("video_en", 16'h0001, {15'h0000, video_en});
      vbl();
      chk("bint", 16'h0001 << l, {8'h00, bint});
      if (l[0]) wr(GCR_SEL_CMD, GCR_CMD_CLEAR, 16'h0000);
      else rd(GCR_SEL_CMD, GCR_CMD_CLEAR, 16'h0000, 4'h0);
      chk("bint", 16'h0000, {8'h00, bint});
    end
    // A clear in the very cycle of a blank must leave the request standing.
    fork
      vbl();
      wr(GCR_SEL_CMD, GCR_CMD_CLEAR, 16'h0000);
    join
    chk("bint", 16'h0080, {8'h00, bint});
    wr(GCR_SEL_CMD, GCR_CMD_CLEAR, 16'h0000);
    chk("bint", 16'h0000, {8'h00, bint});
    wr(GCR_SEL_CMD, GCR_CMD_CTRL, 16'h6000);
    chk("video_en", 16'h0000, {15'h0000, video_en});
    vbl();
    chk("bint", 16'h0000, {8'h00, bint});
    wr(GCR_SEL_CMD, GCR_CMD_CTRL, 16'h6100);
    chk("bint", 16'h0000, {8'h00, bint});
    $display("Interrupt and control test done");
    give_verdict();
  end
endmodule : graphics_control_and_readback_tb
`default_nettype wire
